/* File: pkg/pec_pkg.sv */
package pec_pkg;
	localparam logic [7:0] PEC_OFS_UNLOCK_KEY = 8'h10;
	localparam logic [7:0] PEC_OFS_OUTPUT_ENABLE_CTRL = 8'h12;
	localparam logic [7:0] PEC_OFS_SUPERVISOR_IO_CONFIG = 8'h13;
	localparam logic [7:0] PEC_OFS_STATUS = 8'h20;
	localparam logic [7:0] PEC_RST_OUTPUT_ENABLE_CTRL = 8'h00;
	localparam logic [7:0] PEC_RST_SUPERVISOR_IO_CONFIG = 8'h08;
	localparam logic [7:0] PEC_KEY_VALUE = 8'h7D;
	localparam logic [7:0] PEC_OEN_WMASK = 8'h7F;
	localparam int PEC_BIT_LINEAR_REG = 0;
	localparam int PEC_BIT_SWITCH_ONE = 1;
	localparam int PEC_BIT_SWITCH_TWO = 2;
	localparam int PEC_BIT_SWITCH_THREE = 3;
	localparam int PEC_BIT_GP_OUT1 = 4;
	localparam int PEC_BIT_GP_OUT2 = 5;
	localparam int PEC_BIT_GP_OUT3 = 6;
	localparam int PEC_BIT_UVLO_LO = 0;
	localparam int PEC_BIT_TIGHT = 2;
	localparam int PEC_BIT_DELAY_LO = 3;
	localparam int PEC_BIT_PIN_ONE_MODE = 5;
	localparam int PEC_BIT_OUT_TWO_TYPE = 6;
	localparam int PEC_BIT_HOLD_SEL = 7;
	localparam int PEC_CLK_HZ = 100_000_000;
	localparam int PEC_TICK_PER_MS = 100_000;
	localparam int PEC_DLY0_MS = 10;
	localparam int PEC_DLY1_MS = 20;
	localparam int PEC_DLY2_MS = 50;
	localparam int PEC_DLY3_MS = 150;
	localparam int PEC_HOLD_SHORT_S = 8;
	localparam int PEC_HOLD_LONG_S = 15;
	localparam int PEC_MS_PER_S = 1000;
	localparam logic [1:0] PEC_DLY_RESET = 2'h1;
	localparam logic [1:0] PEC_UVLO_RESET = 2'h0;
	typedef struct packed {
		logic [7:0] adr;
		logic [7:0] dat;
		logic we;
		logic sel;
	} pec_req_t;
	typedef struct packed {
		logic linear_reg_on;
		logic switch_one_on;
		logic switch_two_on;
		logic switch_three_on;
	} pec_power_t;
	typedef struct packed {
		logic hold_long;
		logic out_two_drive_type;
		logic pin_one_mode;
		logic [1:0] good_assert_delay;
		logic supervisor_tight_sel;
		logic [1:0] uvlo_sel;
	} pec_cfg_t;
endpackage

/* File: verilog/pec_ms_timer.sv */
`timescale 1ns/1ps
`default_nettype none
module pec_ms_timer #(
	parameter int TICK_PER_MS = 100_000
) (
	// Clock and reset.
	input wire logic sys_clk,
	input wire logic rst,
	// Control.
	input wire logic run,
	input wire logic [15:0] limit_ms,
	// Result.
	output logic done
);
	logic [16:0] tick;
	logic [15:0] ms;
	wire tick_end = tick == 17'(TICK_PER_MS - 1);
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			tick <= 17'h00000;
			ms <= 16'h0000;
			done <= 1'b0;
		end else if (!run) begin
			tick <= 17'h00000;
			ms <= 16'h0000;
			done <= 1'b0;
		end else if (!done) begin
			tick <= tick_end ? 17'h00000 : tick + 17'h00001;
			if (tick_end) begin
				ms <= ms + 16'h0001;
				done <= (ms + 16'h0001) >= limit_ms;
			end
		end
	end
endmodule
`default_nettype wire

/* File: verilog/pec_regs.sv */
// Local design decision: the Wishbone interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module pec_regs #(
	parameter int TICK_PER_MS = pec_pkg::PEC_TICK_PER_MS,
	parameter logic [7:0] KEY = pec_pkg::PEC_KEY_VALUE
) (
	// Clock and reset.
	input wire logic sys_clk,
	input wire logic rst,
	// Wishbone slave.
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [0:0] wb_sel_i,
	input wire logic [7:0] wb_dat_i,
	output logic [7:0] wb_dat_o,
	output logic wb_ack_o,
	output logic wb_err_o,
	// Power sequencer override.
	input wire logic seq_write,
	input wire logic seq_linear_reg_on,
	input wire logic seq_switch_one_on,
	// Stored power-up defaults and their load request.
	input wire logic nv_load,
	input wire pec_pkg::pec_cfg_t nv_cfg,
	// Pin and supervisor inputs.
	input wire logic pin_one_in,
	input wire logic warm_reset_pin_sel,
	input wire logic rails_good,
	// Power controls.
	output var pec_pkg::pec_power_t power,
	output var pec_pkg::pec_cfg_t cfg,
	// Output pins, each as output level and enable.
	output logic gen_output_one_o,
	output logic gen_output_one_oe,
	output logic gen_output_two_o,
	output logic gen_output_two_oe,
	output logic gen_output_three_o,
	output logic gen_output_three_oe,
	// Supervisor outputs.
	output logic power_good,
	output logic [31:0] hold_time_cycles
);
	import pec_pkg::*;

	logic [7:0] oen;
	logic [7:0] cfg_q;
	logic unlocked;
	logic [15:0] delay_ms;
	logic delay_done;

	function automatic logic [15:0] delay_of(input logic [1:0] code);
		logic [15:0] r;
		r = 16'(PEC_DLY0_MS);
		unique case (code)
			2'h0: r = 16'(PEC_DLY0_MS);
			2'h1: r = 16'(PEC_DLY1_MS);
			2'h2: r = 16'(PEC_DLY2_MS);
			2'h3: r = 16'(PEC_DLY3_MS);
		endcase
		return r;
	endfunction

	function automatic logic [31:0] hold_of(input logic long_sel);
		logic [31:0] r;
		r = 32'(PEC_HOLD_SHORT_S * PEC_MS_PER_S * TICK_PER_MS);
		if (long_sel)
			r = 32'(PEC_HOLD_LONG_S * PEC_MS_PER_S * TICK_PER_MS);
		return r;
	endfunction

	// The key register and unmapped addresses read as zero.
	function automatic logic [7:0] read_of(input logic [7:0] adr, input logic [7:0] en, input logic [7:0] cf,
		input logic [7:0] st);
		logic [7:0] r;
		r = 8'h00;
		case (adr)
			PEC_OFS_OUTPUT_ENABLE_CTRL: r = en;
			PEC_OFS_SUPERVISOR_IO_CONFIG: r = cf;
			PEC_OFS_STATUS: r = st;
			default: r = 8'h00;
		endcase
		return r;
	endfunction

	wire req = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
	wire hit_key = wb_adr_i == PEC_OFS_UNLOCK_KEY;
	wire hit_oen = wb_adr_i == PEC_OFS_OUTPUT_ENABLE_CTRL;
	wire hit_cfg = wb_adr_i == PEC_OFS_SUPERVISOR_IO_CONFIG;
	wire hit_sts = wb_adr_i == PEC_OFS_STATUS;
	wire mapped = hit_key || hit_oen || hit_cfg || hit_sts;
	wire wr = req && wb_we_i && wb_sel_i[0];
	wire wr_key = wr && hit_key;
	wire wr_oen = wr && hit_oen && unlocked;
	wire wr_cfg = wr && hit_cfg && unlocked;
	wire pin_in_mode = cfg_q[PEC_BIT_PIN_ONE_MODE];
	wire push_pull = cfg_q[PEC_BIT_OUT_TWO_TYPE];
	wire [7:0] status = {5'h00, delay_done, rails_good, unlocked};

	// Unmapped addresses also get an error answer.
	wire [7:0] rd_data = read_of(wb_adr_i, oen, cfg_q, status);

	// Output two follows pin one in input mode, else its own bit.
	wire out_two_level = pin_in_mode ? pin_one_in : oen[PEC_BIT_GP_OUT2];
	wire out_one_level = oen[PEC_BIT_GP_OUT1];

	// Next value of the output-enable register.
	logic [7:0] next_oen;
	always_comb begin
		next_oen = oen;
		if (wr_oen)
			next_oen = wb_dat_i & PEC_OEN_WMASK;
		if (seq_write) begin
			next_oen[PEC_BIT_LINEAR_REG] = seq_linear_reg_on;
			next_oen[PEC_BIT_SWITCH_ONE] = seq_switch_one_on;
		end
	end

	// A key write sets or clears the lock; any protected write relocks.
	logic next_unlocked;
	always_comb begin
		next_unlocked = unlocked;
		if (wr_key)
			next_unlocked = wb_dat_i == KEY;
		else if (wr && (hit_oen || hit_cfg))
			next_unlocked = 1'b0;
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			unlocked <= 1'b0;
		end else begin
			unlocked <= next_unlocked;
		end
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			oen <= PEC_RST_OUTPUT_ENABLE_CTRL;
		end else begin
			oen <= next_oen;
		end
	end

	// A load of the stored defaults wins over a bus write in the same cycle.
	logic [7:0] next_cfg;
	always_comb begin
		next_cfg = cfg_q;
		if (wr_cfg)
			next_cfg = wb_dat_i;
		if (nv_load)
			next_cfg = nv_cfg;
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			cfg_q <= PEC_RST_SUPERVISOR_IO_CONFIG;
		end else begin
			cfg_q <= next_cfg;
		end
	end

	// A request is answered on the next edge; the answer blocks a second take.
	wire next_ack = req && mapped;
	wire next_err = req && !mapped;
	wire [7:0] next_dat = req ? rd_data : 8'h00;

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			wb_ack_o <= 1'b0;
		end else begin
			wb_ack_o <= next_ack;
		end
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			wb_err_o <= 1'b0;
		end else begin
			wb_err_o <= next_err;
		end
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			wb_dat_o <= 8'h00;
		end else begin
			wb_dat_o <= next_dat;
		end
	end

	assign delay_ms = delay_of(cfg_q[PEC_BIT_DELAY_LO +: 2]);

	pec_ms_timer #(
		.TICK_PER_MS(TICK_PER_MS)
	) u_timer (
		.sys_clk(sys_clk),
		.rst(rst),
		.run(rails_good),
		.limit_ms(delay_ms),
		.done(delay_done)
	);

	// Next values of the registered controls and pins.
	wire pec_power_t next_power = {
		oen[PEC_BIT_LINEAR_REG],
		oen[PEC_BIT_SWITCH_ONE],
		oen[PEC_BIT_SWITCH_TWO],
		oen[PEC_BIT_SWITCH_THREE]
	};
	// Pin one is open-drain: it pulls low only, and never in input mode.
	wire next_out_one_oe = !pin_in_mode && !out_one_level;
	// Open-drain pulls low only; push-pull drives both levels.
	wire next_out_two_o = out_two_level;
	wire next_out_two_oe = push_pull || !out_two_level;
	// Output three is open-drain and released in warm-reset mode.
	wire next_out_three_oe = !warm_reset_pin_sel && !oen[PEC_BIT_GP_OUT3];
	// Rising edge waits the delay; falling edge is immediate.
	wire next_power_good = rails_good && delay_done;
	wire [31:0] next_hold = hold_of(cfg_q[PEC_BIT_HOLD_SEL]);

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			power <= '0;
		end else begin
			power <= next_power;
		end
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			cfg <= PEC_RST_SUPERVISOR_IO_CONFIG;
		end else begin
			cfg <= cfg_q;
		end
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			gen_output_one_o <= 1'b0;
		end else begin
			gen_output_one_o <= 1'b0;
		end
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			gen_output_one_oe <= 1'b0;
		end else begin
			gen_output_one_oe <= next_out_one_oe;
		end
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			gen_output_two_o <= 1'b0;
		end else begin
			gen_output_two_o <= next_out_two_o;
		end
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			gen_output_two_oe <= 1'b0;
		end else begin
			gen_output_two_oe <= next_out_two_oe;
		end
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			gen_output_three_o <= 1'b0;
		end else begin
			gen_output_three_o <= 1'b0;
		end
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			gen_output_three_oe <= 1'b0;
		end else begin
			gen_output_three_oe <= next_out_three_oe;
		end
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			power_good <= 1'b0;
		end else begin
			power_good <= next_power_good;
		end
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			hold_time_cycles <= 32'h00000000;
		end else begin
			hold_time_cycles <= next_hold;
		end
	end
endmodule
`default_nettype wire

/* File: verif/pec_regs_properties.sv */
`timescale 1ns/1ps
`default_nettype none
module pec_regs_chk import pec_pkg::*; #(parameter int TICK_PER_MS = 10) (
	input wire logic sys_clk, rst, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, wb_err_o,
	input wire logic seq_write, seq_linear_reg_on, rails_good, power_good,
	input wire logic [7:0] wb_adr_i, wb_dat_o,
	input wire pec_power_t power,
	input wire pec_cfg_t cfg,
	input wire logic [31:0] hold_time_cycles
);
	wire req = wb_cyc_i & wb_stb_i & !wb_ack_o & !wb_err_o;
	wire mapped = wb_adr_i inside {8'h10, 8'h12, 8'h13, 8'h20};
	wire rd = req & !wb_we_i;
	default clocking @(posedge sys_clk); endclocking
	default disable iff (rst);
	property p_ack; req & mapped |=> wb_ack_o & !wb_err_o; endproperty
	a_ack: assert property (p_ack) else $error("no ack");
	property p_err; req & !mapped |=> wb_err_o & !wb_ack_o; endproperty
	a_err: assert property (p_err) else $error("no err");
	property p_pulse; wb_ack_o |=> !wb_ack_o; endproperty
	a_pulse: assert property (p_pulse) else $error("ack too long");
	property p_key; rd & wb_adr_i == 8'h10 |=> wb_dat_o == 8'h00; endproperty
	a_key: assert property (p_key) else $error("key readback");
	property p_rsv; rd & wb_adr_i == 8'h12 |=> !wb_dat_o[7]; endproperty
	a_rsv: assert property (p_rsv) else $error("bit7 set");
	property p_fall; $fell(rails_good) |-> ##[1:2] !power_good; endproperty
	a_fall: assert property (p_fall) else $error("good late fall");
	property p_rise; $rose(power_good) |-> rails_good && $past(rails_good, 8); endproperty
	a_rise: assert property (p_rise) else $error("good early");
	property p_seq; seq_write |-> ##2 power.linear_reg_on == $past(seq_linear_reg_on, 2); endproperty
	a_seq: assert property (p_seq) else $error("seq lost");
	property p_hold;
		!$past(rst) && $stable(cfg) |-> hold_time_cycles == (cfg.hold_long ? 15000 : 8000) * TICK_PER_MS;
	endproperty
	a_hold: assert property (p_hold) else $error("hold time");
endmodule
bind pec_regs pec_regs_chk #(.TICK_PER_MS(TICK_PER_MS)) i_chk (.*);
`default_nettype wire

/* File: verif/tb_pec_regs.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_pec_regs;
	import pec_pkg::*;
	logic sys_clk = 0, rst = 1, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0, seq_write = 0, seq_linear_reg_on = 0;
	logic seq_switch_one_on = 0, nv_load = 0, pin_one_in = 0, warm_reset_pin_sel = 0, rails_good = 0;
	logic [7:0] wb_adr_i = 0, wb_dat_i = 0, wb_dat_o, rdat;
	logic [0:0] wb_sel_i = 1;
	logic wb_ack_o, wb_err_o, gen_output_one_o, gen_output_one_oe, gen_output_two_o, gen_output_two_oe;
	logic gen_output_three_o, gen_output_three_oe, power_good, got_err;
	logic [31:0] hold_time_cycles;
	pec_cfg_t nv_cfg = 8'h08, cfg;
	pec_power_t power;
	int n_fail = 0, check_count = 0;
	pec_regs #(.TICK_PER_MS(10)) i_dut (.*);
	initial forever #5 sys_clk = ~sys_clk;
	task automatic chk(input logic [31:0] got, exp);
		check_count++;
		if (got !== exp) begin
			n_fail++;
			$display("BAD %0t got %0h exp %0h", $time, got, exp);
		end
	endtask
	task automatic bus(input logic we, input logic [7:0] a, d);
		wb_cyc_i <= 1;
		wb_stb_i <= 1;
		wb_we_i <= we;
		wb_adr_i <= a;
		wb_dat_i <= d;
		@(posedge sys_clk);
		while (wb_ack_o !== 1 && wb_err_o !== 1) @(posedge sys_clk);
		rdat = wb_dat_o;
		got_err = wb_err_o;
		wb_cyc_i <= 0;
		wb_stb_i <= 0;
		@(posedge sys_clk);
	endtask
	task automatic rd(input logic [7:0] a, e);
		bus(0, a, 8'h00);
		chk(rdat, e);
	endtask
	task automatic t_reset;
		rd(8'h10, 8'h00);
		rd(8'h12, 8'h00);
		rd(8'h13, 8'h08);
		chk(cfg, 8'h08);
		$display("reset done");
	endtask
	task automatic t_lock;
		bus(1, 8'h12, 8'hFF);
		rd(8'h12, 8'h00);
		bus(1, 8'h13, 8'h00);
		rd(8'h13, 8'h08);
		$display("lock done");
	endtask
	task automatic t_enable;
		bus(1, 8'h10, 8'h7D);
		bus(1, 8'h12, 8'hFF);
		rd(8'h12, 8'h7F);
		chk(power, 4'hF);
		bus(1, 8'h12, 8'h00);
		rd(8'h12, 8'h7F);
		$display("enable done");
	endtask
	task automatic t_seq;
		seq_write <= 1;
		@(posedge sys_clk);
		seq_write <= 0;
		@(posedge sys_clk);
		rd(8'h12, 8'h7C);
		chk(power, 4'h3);
		$display("seq done");
	endtask
	task automatic t_cfg;
		bus(1, 8'h10, 8'h7D);
		bus(1, 8'h13, 8'hD7);
		rd(8'h13, 8'hD7);
		chk(cfg, 8'hD7);
		chk(hold_time_cycles, 150000);
		$display("cfg done");
	endtask
	task automatic t_pg;
		rails_good <= 1;
		repeat (450) @(posedge sys_clk);
		chk(power_good, 0);
		repeat (100) @(posedge sys_clk);
		chk(power_good, 1);
		rails_good <= 0;
		repeat (3) @(posedge sys_clk);
		chk(power_good, 0);
		$display("good done");
	endtask
	task automatic t_pins;
		chk(gen_output_one_oe, 0);
		chk({gen_output_two_o, gen_output_two_oe}, 2'h3);
		chk(gen_output_three_oe, 0);
		bus(1, 8'h10, 8'h7D);
		bus(1, 8'h12, 8'h00);
		chk(gen_output_one_oe, 1);
		chk({gen_output_two_o, gen_output_two_oe}, 2'h1);
		chk({gen_output_three_o, gen_output_three_oe}, 2'h1);
		warm_reset_pin_sel <= 1;
		repeat (2) @(posedge sys_clk);
		chk(gen_output_three_oe, 0);
		bus(1, 8'h10, 8'h7D);
		bus(1, 8'h13, 8'h27);
		pin_one_in <= 1;
		repeat (2) @(posedge sys_clk);
		chk(gen_output_one_oe, 0);
		chk({gen_output_two_o, gen_output_two_oe}, 2'h2);
		pin_one_in <= 0;
		repeat (2) @(posedge sys_clk);
		chk({gen_output_two_o, gen_output_two_oe}, 2'h1);
		wb_sel_i <= 0;
		bus(1, 8'h10, 8'h7D);
		wb_sel_i <= 1;
		bus(1, 8'h12, 8'hFF);
		rd(8'h12, 8'h00);
		rd(8'h20, 8'h00);
		$display("pins done");
	endtask
	task automatic t_nv;
		nv_load <= 1;
		@(posedge sys_clk);
		nv_load <= 0;
		@(posedge sys_clk);
		rd(8'h13, 8'h08);
		chk(hold_time_cycles, 80000);
		bus(0, 8'h55, 8'h00);
		chk(got_err, 1);
		$display("load done");
	endtask
	task automatic results;
		$display("checks %0d fails %0d", check_count, n_fail);
		if (n_fail == 0 && check_count > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	initial begin
		repeat (10) @(posedge sys_clk);
		rst <= 0;
		@(posedge sys_clk);
		t_reset();
		t_lock();
		t_enable();
		t_seq();
		t_cfg();
		t_pg();
		t_pins();
		t_nv();
		results();
	end
	initial begin
		repeat (5000) @(posedge sys_clk);
		n_fail++;
		results();
	end
endmodule
`default_nettype wire
